/* design/aim_rec_mem.sv */
// record memory: per-channel maximum and minimum, registered read
`timescale 1ns/1ps
module aim_rec_mem (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // access
    aim_rec_if.mem rec
);
    import aim_pkg::*;
    logic [DW-1:0] max_q [NCH];
    logic [DW-1:0] min_q [NCH];
    logic [DW-1:0] rmax_q;
    logic [DW-1:0] rmin_q;

    always_ff @(posedge aclk) begin
        if (rec.we) begin
            max_q[rec.wch] <= rec.wmax;
            min_q[rec.wch] <= rec.wmin;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rmax_q <= VAL_ZERO;
            rmin_q <= VAL_ONES;
        end else begin
            rmax_q <= max_q[rec.rch];
            rmin_q <= min_q[rec.rch];
        end
    end

    assign rec.rmax = rmax_q;
    assign rec.rmin = rmin_q;
endmodule

/* design/aim_top.sv */
// analog input monitor: alarms, records, averaging, calibration, locate
`timescale 1ns/1ps
module aim_top #(
    parameter logic [31:0] LOCATE_CYCLES = aim_pkg::LOCATE_CYC,
    parameter logic [31:0] CAL_CYCLES = aim_pkg::CAL_CYC
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [aim_pkg::AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [aim_pkg::AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // converter results, same clock
    input wire logic smp_valid,
    input wire logic [aim_pkg::CW-1:0] smp_ch,
    input wire logic [aim_pkg::DW-1:0] smp_data,
    input wire logic smp_open,
    // converter control
    output logic [3*aim_pkg::NCH-1:0] adc_range,
    output logic adc_integ_sel,
    output logic adc_cal_run,
    output logic adc_cal_commit,
    // indicators
    output logic status_led,
    output logic alarm_led
);
    import aim_pkg::*;
    logic [2:0] ctrl_q;
    logic [NCH-1:0] avgsel_q;
    logic [CW-1:0] chsel_q;
    logic [2:0] rng_pend_q [NCH];
    logic [2:0] rng_q [NCH];
    logic [DW-1:0] hilim_q [NCH];
    logic [DW-1:0] lolim_q [NCH];
    logic [1:0] hmode_q [NCH];
    logic [1:0] lmode_q [NCH];
    logic [DW-1:0] val_q [NCH];
    logic [NCH-1:0] hst_q;
    logic [NCH-1:0] lst_q;
    logic [NCH-1:0] rec_init_q;
    logic [31:0] loc_cnt_q;
    logic [31:0] cal_cnt_q;
    aim_cal_t cal_q;
    logic cal_ok_q;
    logic commit_q;
    // bus slave state
    logic aw_hold_q;
    logic w_hold_q;
    logic [AW-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic rvalid_q;
    logic rpend_q;
    logic [AW-1:0] araddr_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    aim_rec_if rec ();
    aim_rec_mem u_mem (
        .aclk(aclk),
        .aresetn(aresetn),
        .rec(rec)
    );
    // write channel handshake
    assign s_axi_awready = !aw_hold_q && !bvalid_q;
    assign s_axi_wready = !w_hold_q && !bvalid_q;
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire have_aw = aw_hold_q || aw_take;
    wire have_w = w_hold_q || w_take;
    wire do_wr = have_aw && have_w;
    wire [AW-1:0] wa = aw_hold_q ? awaddr_q : s_axi_awaddr;
    wire [31:0] wd = w_hold_q ? wdata_q : s_axi_wdata;
    wire [3:0] ws = w_hold_q ? wstrb_q : s_axi_wstrb;
    wire wlo = do_wr && ws[0];
    wire whi = do_wr && ws[1];
    wire wr_ctrl = wlo && wa == A_CTRL;
    wire wr_cmd = wlo && wa == A_CMD;
    wire wr_avg = wlo && wa == A_AVGSEL;
    wire wr_chsel = wlo && wa == A_CHSEL;
    wire wr_rng = wlo && wa == A_RANGE;
    wire wr_mode = wlo && wa == A_MODE;
    wire wr_clr = wlo && wa == A_CLR;
    wire [DW-1:0] wmask = {{8{whi}}, {8{wlo}}};
    wire wr_hil = do_wr && wa == A_HILIM;
    wire wr_lol = do_wr && wa == A_LOLIM;
    wire cmd_cal = wr_cmd && wd[CMD_CAL];
    wire cmd_apcal = wr_cmd && wd[CMD_APPLY_CAL];
    wire cmd_aprng = wr_cmd && wd[CMD_APPLY_RNG];
    wire cmd_loc = wr_cmd && wd[CMD_LOCATE];
    // sample path
    wire [2:0] srng = rng_q[smp_ch];
    wire burn = smp_open && srng == RNG_4_20MA;
    wire [DW-1:0] burn_val = ctrl_q[CTRL_BURN_UP] ? VAL_ONES
                                                  : VAL_ZERO;
    wire [DW-1:0] sval = burn ? burn_val : smp_data;
    wire s_hi = sval > hilim_q[smp_ch];
    wire s_lo = sval < lolim_q[smp_ch];
    // channel state, one generate copy per channel
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            wire hit = smp_valid && smp_ch == CW'(g);
            wire sel = chsel_q == CW'(g);
            wire clr_h = wr_clr && sel && wd[0];
            wire clr_l = wr_clr && sel && wd[1];
            logic hst_d;
            logic lst_d;
            always_comb begin
                hst_d = hst_q[g];
                lst_d = lst_q[g];
                case (hmode_q[g])
                    MODE_LATCH: hst_d = (hit && s_hi) || (hst_q[g] && !clr_h);
                    MODE_MOM: hst_d = hit ? s_hi : hst_q[g];
                    default: hst_d = 1'b0;
                endcase
                case (lmode_q[g])
                    MODE_LATCH: lst_d = (hit && s_lo) || (lst_q[g] && !clr_l);
                    MODE_MOM: lst_d = hit ? s_lo : lst_q[g];
                    default: lst_d = 1'b0;
                endcase
            end
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    hst_q[g] <= 1'b0;
                    lst_q[g] <= 1'b0;
                    rng_pend_q[g] <= RNG_RESET;
                    rng_q[g] <= RNG_RESET;
                    hilim_q[g] <= VAL_ONES;
                    lolim_q[g] <= VAL_ZERO;
                    hmode_q[g] <= MODE_DIS;
                    lmode_q[g] <= MODE_DIS;
                    val_q[g] <= VAL_ZERO;
                end else begin
                    hst_q[g] <= hst_d;
                    lst_q[g] <= lst_d;
                    if (wr_rng && sel)
                        rng_pend_q[g] <= wd[2:0];
                    if (cmd_aprng)
                        rng_q[g] <= rng_pend_q[g];
                    if (wr_hil && sel)
                        hilim_q[g] <= (wd[DW-1:0] & wmask) | (hilim_q[g] & ~wmask);
                    if (wr_lol && sel)
                        lolim_q[g] <= (wd[DW-1:0] & wmask) | (lolim_q[g] & ~wmask);
                    if (wr_mode && sel) begin
                        hmode_q[g] <= wd[1:0];
                        lmode_q[g] <= wd[3:2];
                    end
                    if (hit)
                        val_q[g] <= sval;
                end
            end
            assign adc_range[3*g +: 3] = rng_q[g];
        end
    endgenerate
    // max/min record update: read-modify-write through registered memory
    logic s1_v_q;
    logic [CW-1:0] s1_ch_q;
    logic [DW-1:0] s1_val_q;
    wire [NCH-1:0] rec_clr = (wr_clr && wd[2]) ? (NCH'(1) << chsel_q) : '0;
    wire s1_init = rec_init_q[s1_ch_q];
    wire [DW-1:0] nmax = (s1_init || s1_val_q > rec.rmax) ? s1_val_q
                                                          : rec.rmax;
    wire [DW-1:0] nmin = (s1_init || s1_val_q < rec.rmin) ? s1_val_q
                                                          : rec.rmin;
    assign rec.rch = smp_valid ? smp_ch : chsel_q;
    assign rec.we = s1_v_q;
    assign rec.wch = s1_ch_q;
    assign rec.wmax = nmax;
    assign rec.wmin = nmin;
    logic rd_mm_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_v_q <= 1'b0;
            s1_ch_q <= '0;
            s1_val_q <= VAL_ZERO;
            rec_init_q <= '1;
        end else begin
            s1_v_q <= smp_valid && !(s1_v_q && s1_ch_q == smp_ch);
            s1_ch_q <= smp_ch;
            s1_val_q <= sval;
            rec_init_q <= (rec_init_q & ~((s1_v_q ? NCH'(1) << s1_ch_q
                          : '0))) | rec_clr;
        end
    end
    // average of selected channels
    logic [DW+CW-1:0] sum;
    logic [CW:0] cnt;
    always_comb begin
        sum = '0;
        cnt = '0;
        for (int i = 0; i < NCH; i++)
            if (avgsel_q[i]) begin
                sum = sum + (DW+CW)'(val_q[i]);
                cnt = cnt + 1'b1;
            end
    end
    logic [DW-1:0] avg_q;
    // locate timer and calibration sequencer
    wire alm_any = |{hst_q, lst_q};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= '0;
            avgsel_q <= '0;
            chsel_q <= '0;
            loc_cnt_q <= '0;
            cal_cnt_q <= '0;
            cal_q <= CAL_IDLE;
            cal_ok_q <= 1'b0;
            commit_q <= 1'b0;
            avg_q <= VAL_ZERO;
        end else begin
            avg_q <= (cnt == '0) ? VAL_ZERO : DW'(sum / (DW+CW)'(cnt));
            commit_q <= 1'b0;
            if (wr_ctrl)
                ctrl_q <= wd[2:0];
            if (wr_avg)
                avgsel_q <= wd[NCH-1:0];
            if (wr_chsel)
                chsel_q <= wd[CW-1:0];
            if (cmd_loc)
                loc_cnt_q <= LOCATE_CYCLES;
            else if (loc_cnt_q != '0)
                loc_cnt_q <= loc_cnt_q - 1'b1;
            case (cal_q)
                CAL_IDLE: begin
                    if (cmd_cal && ctrl_q[CTRL_PERMIT]) begin
                        cal_q <= CAL_RUN;
                        cal_cnt_q <= CAL_CYCLES;
                        cal_ok_q <= 1'b0;
                    end
                end
                CAL_RUN: begin
                    if (cal_cnt_q <= 32'h1)
                        cal_q <= CAL_WAIT;
                    cal_cnt_q <= cal_cnt_q - 1'b1;
                end
                CAL_WAIT: begin
                    if (cmd_apcal) begin
                        cal_q <= CAL_IDLE;
                        cal_ok_q <= 1'b1;
                        commit_q <= 1'b1;
                    end
                end
                default: cal_q <= CAL_IDLE;
            endcase
        end
    end
    assign adc_integ_sel = ctrl_q[CTRL_INTEG];
    assign adc_cal_run = cal_q == CAL_RUN;
    assign adc_cal_commit = commit_q;
    assign status_led = loc_cnt_q != '0;
    assign alarm_led = alm_any;
    // read mux
    wire [31:0] stat = {27'h0, alm_any, cal_ok_q, cal_q == CAL_WAIT,
                        cal_q == CAL_RUN, loc_cnt_q != '0};
    logic [31:0] rmux;
    logic rhit;
    always_comb begin
        rhit = 1'b1;
        case (araddr_q)
            A_CTRL: rmux = {29'h0, ctrl_q};
            A_CMD: rmux = 32'h0;
            A_STAT: rmux = stat;
            A_AVGSEL: rmux = {24'h0, avgsel_q};
            A_AVG: rmux = {16'h0, avg_q};
            A_ALM: rmux = {16'h0, lst_q, hst_q};
            A_CHSEL: rmux = {29'h0, chsel_q};
            A_RANGE: rmux = {25'h0, rng_q[chsel_q], 1'b0, rng_pend_q[chsel_q]};
            A_HILIM: rmux = {16'h0, hilim_q[chsel_q]};
            A_LOLIM: rmux = {16'h0, lolim_q[chsel_q]};
            A_MODE: rmux = {28'h0, lmode_q[chsel_q], hmode_q[chsel_q]};
            A_VAL: rmux = {16'h0, val_q[chsel_q]};
            A_MAX: rmux = {16'h0, rec.rmax};
            A_MIN: rmux = {16'h0, rec.rmin};
            A_CLR: rmux = 32'h0;
            default: begin
                rmux = 32'h0;
                rhit = 1'b0;
            end
        endcase
    end
    assign s_axi_arready = !rpend_q && !rvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = RESP_OK;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    wire rec_idle = !s1_v_q && !smp_valid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            bvalid_q <= 1'b0;
            rpend_q <= 1'b0;
            rvalid_q <= 1'b0;
            araddr_q <= '0;
            rdata_q <= '0;
            rresp_q <= RESP_OK;
            rd_mm_q <= 1'b0;
        end else begin
            if (aw_take)
                awaddr_q <= s_axi_awaddr;
            if (w_take) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            aw_hold_q <= have_aw && !do_wr;
            w_hold_q <= have_w && !do_wr;
            if (do_wr)
                bvalid_q <= 1'b1;
            else if (s_axi_bready)
                bvalid_q <= 1'b0;
            if (s_axi_arvalid && s_axi_arready) begin
                araddr_q <= s_axi_araddr;
                rpend_q <= 1'b1;
                rd_mm_q <= 1'b0;
            end else if (rpend_q) begin
                // two idle record-port cycles give registered max/min data
                rd_mm_q <= rec_idle;
                if (rd_mm_q && rec_idle) begin
                    rpend_q <= 1'b0;
                    rvalid_q <= 1'b1;
                    rdata_q <= rmux;
                    rresp_q <= rhit ? RESP_OK : RESP_SLVERR;
                end
            end
            if (rvalid_q && s_axi_rready)
                rvalid_q <= 1'b0;
        end
    end
endmodule

/* pkg/aim_pkg.sv */
// package: register map, field layout and timing constants of the monitor
package aim_pkg;
    localparam int NCH = 8;
    localparam int DW = 16;
    localparam int CW = 3;
    localparam int AW = 8;
    localparam int CLK_HZ = 100_000_000;
    localparam int LOCATE_SEC = 10;
    localparam int CAL_SEC = 20;
    localparam longint LOCATE_CYC_L = longint'(LOCATE_SEC) * CLK_HZ;
    localparam longint CAL_CYC_L = longint'(CAL_SEC) * CLK_HZ;
    localparam logic [31:0] LOCATE_CYC = LOCATE_CYC_L[31:0];
    localparam logic [31:0] CAL_CYC = CAL_CYC_L[31:0];
    localparam logic [15:0] VAL_ONES = 16'hFFFF;
    localparam logic [15:0] VAL_ZERO = 16'h0000;
    // global registers, then per-channel registers from A_RANGE selected by A_CHSEL
    localparam logic [AW-1:0] A_CTRL = 8'h00;
    localparam logic [AW-1:0] A_CMD = 8'h04;
    localparam logic [AW-1:0] A_STAT = 8'h08;
    localparam logic [AW-1:0] A_AVGSEL = 8'h0C;
    localparam logic [AW-1:0] A_AVG = 8'h10;
    localparam logic [AW-1:0] A_ALM = 8'h14;
    localparam logic [AW-1:0] A_CHSEL = 8'h18;
    localparam logic [AW-1:0] A_RANGE = 8'h1C;
    localparam logic [AW-1:0] A_HILIM = 8'h20;
    localparam logic [AW-1:0] A_LOLIM = 8'h24;
    localparam logic [AW-1:0] A_MODE = 8'h28;
    localparam logic [AW-1:0] A_VAL = 8'h2C;
    localparam logic [AW-1:0] A_MAX = 8'h30;
    localparam logic [AW-1:0] A_MIN = 8'h34;
    localparam logic [AW-1:0] A_CLR = 8'h38;
    // control bits
    localparam int CTRL_BURN_UP = 0;
    localparam int CTRL_INTEG = 1;
    localparam int CTRL_PERMIT = 2;
    // command bits (write one)
    localparam int CMD_LOCATE = 0;
    localparam int CMD_CAL = 1;
    localparam int CMD_APPLY_CAL = 2;
    localparam int CMD_APPLY_RNG = 3;
    // status bits
    localparam int ST_LOCATE = 0;
    localparam int ST_CAL_BUSY = 1;
    localparam int ST_CAL_DONE = 2;
    localparam int ST_CAL_OK = 3;
    localparam int ST_ANY_ALM = 4;
    // range codes: bit 2 marks a current range
    localparam logic [2:0] RNG_4_20MA = 3'h4;
    localparam logic [2:0] RNG_RESET = 3'h0;
    localparam logic [1:0] MODE_DIS = 2'h0;
    localparam logic [1:0] MODE_LATCH = 2'h1;
    localparam logic [1:0] MODE_MOM = 2'h2;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        CAL_IDLE = 3'b001,
        CAL_RUN = 3'b010,
        CAL_WAIT = 3'b100
    } aim_cal_t;
endpackage

/* pkg/aim_rec_if.sv */
// interface: per-channel record read and write port between top and record memory
`timescale 1ns/1ps
interface aim_rec_if;
    logic we;
    logic [aim_pkg::CW-1:0] wch;
    logic [aim_pkg::DW-1:0] wmax;
    logic [aim_pkg::DW-1:0] wmin;
    logic [aim_pkg::CW-1:0] rch;
    logic [aim_pkg::DW-1:0] rmax;
    logic [aim_pkg::DW-1:0] rmin;
    modport user (output we, wch, wmax, wmin, rch, input rmax, rmin);
    modport mem (input we, wch, wmax, wmin, rch, output rmax, rmin);
endinterface

/* verification/aim_adc_model.sv */
// converter model: delivers one conversion result per call
`timescale 1ns/1ps
module aim_adc_model (
    // clock
    input logic aclk,
    // conversion results
    output logic smp_valid,
    output logic [aim_pkg::CW-1:0] smp_ch,
    output logic [aim_pkg::DW-1:0] smp_data,
    output logic smp_open
);
    import aim_pkg::*;
    initial begin
        smp_valid = 1'b0;
        smp_ch = '0;
        smp_data = '0;
        smp_open = 1'b0;
    end
    // one-cycle result; lines inverted once it is over
    task automatic send(input logic [CW-1:0] c, input logic [DW-1:0] d,
            input logic o);
        @(posedge aclk);
        smp_valid <= 1'b1;
        smp_ch <= c;
        smp_data <= d;
        smp_open <= o;
        @(posedge aclk);
        smp_valid <= 1'b0;
        smp_ch <= ~c;
        smp_data <= ~d;
        smp_open <= ~o;
    endtask
endmodule

/* verification/aim_assertions.sv */
// checker: port-level timing relations of the monitor
`timescale 1ns/1ps
module aim_assertions #(
    parameter logic [31:0] LOCATE_CYCLES = aim_pkg::LOCATE_CYC,
    parameter logic [31:0] CAL_CYCLES = aim_pkg::CAL_CYC
) (
    // clock and reset
    input logic aclk,
    input logic aresetn,
    // register bus
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    // samples, calibration control and indicators
    input logic smp_valid,
    input logic adc_cal_run,
    input logic adc_cal_commit,
    input logic status_led,
    input logic alarm_led
);
    import aim_pkg::*;
    localparam int RD_MIN = 3;
    localparam int RD_MAX = 16;
    logic [31:0] led_cnt_q, led_cnt_d, cal_cnt_q, cal_cnt_d;
    assign led_cnt_d = status_led ? led_cnt_q + 32'h1 : 32'h0;
    assign cal_cnt_d = adc_cal_run ? cal_cnt_q + 32'h1 : 32'h0;
    always_ff @(posedge aclk) led_cnt_q <= aresetn ? led_cnt_d : 32'h0;
    always_ff @(posedge aclk) cal_cnt_q <= aresetn ? cal_cnt_d : 32'h0;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    locate_len_a:
        assert property ($fell(status_led) |->
            led_cnt_q >= LOCATE_CYCLES - 32'h1)
        else $error("locate indication ended early");
    locate_max_a:
        assert property (led_cnt_q <= LOCATE_CYCLES + 32'h1)
        else $error("locate indication too long");
    cal_len_a:
        assert property ($fell(adc_cal_run) |->
            cal_cnt_q >= CAL_CYCLES - 32'h1)
        else $error("calibration ended early");
    cal_max_a:
        assert property (cal_cnt_q <= CAL_CYCLES + 32'h1)
        else $error("calibration too long");
    commit_pulse_a:
        assert property (adc_cal_commit |-> !adc_cal_run ##1 !adc_cal_commit)
        else $error("commit not a lone pulse after calibration");
    alarm_cause_a:
        assert property ($rose(alarm_led) |-> $past(smp_valid) ||
            $past(smp_valid, 2) || $past(smp_valid, 3))
        else $error("alarm rose without a sample");
    write_resp_a:
        assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
            s_axi_wready |=> s_axi_bvalid)
        else $error("write not answered");
    read_resp_a:
        assert property (s_axi_arvalid && s_axi_arready |->
            ##[RD_MIN:RD_MAX] s_axi_rvalid)
        else $error("read not answered");
    read_drop_a:
        assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data held after transfer");
    locate_c: cover property ($fell(status_led));
    cal_c: cover property ($fell(adc_cal_run));
    alarm_c: cover property ($rose(alarm_led));
endmodule

/* verification/tb_aim_top.sv */
// testbench: register-level scenarios for the analog input monitor
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    check_count++; \
    if ((got) !== (exp)) begin \
        error_cnt++; \
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
    end \
end
module tb_aim_top;
    import aim_pkg::*;
    logic aclk, aresetn;
    logic [AW-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rresp_s, bresp_s;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, smp_valid, smp_open;
    logic [CW-1:0] smp_ch;
    logic [DW-1:0] smp_data;
    logic [3*NCH-1:0] adc_range;
    logic adc_integ_sel, adc_cal_run, adc_cal_commit, status_led, alarm_led;
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;
    int commit_n = 0;
    logic [31:0] t_mode [3] = '{32'hA, 32'h5, 32'h0};
    logic [2:0] t_ch [7] = '{3'h0, 3'h1, 3'h2, 3'h0, 3'h1, 3'h0, 3'h1};
    logic [15:0] t_dat [7] = '{16'hC8, 16'hC8, 16'hC8, 16'h32, 16'h32,
        16'h5, 16'h5};
    logic [15:0] t_alm [7] = '{16'h1, 16'h3, 16'h3, 16'h2, 16'h2,
        16'h102, 16'h302};
    aim_top #(.LOCATE_CYCLES(32'd20), .CAL_CYCLES(32'd40)) DUT (.*);
    aim_adc_model adc (.*);
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            complete_run();
        end
    end
    always @(negedge aclk) begin
        if (adc_cal_commit) commit_n++;
    end
    task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
        logic aw_t, w_t, b_t;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        b_t = 1'b0;
        while (!b_t) begin
            @(negedge aclk);
            aw_t = s_axi_awvalid && s_axi_awready;
            w_t = s_axi_wvalid && s_axi_wready;
            b_t = s_axi_bvalid;
            bresp_s = s_axi_bresp;
            @(posedge aclk);
            if (aw_t) s_axi_awvalid <= 1'b0;
            if (w_t) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [AW-1:0] a);
        logic ar_t, r_t;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        r_t = 1'b0;
        while (!r_t) begin
            @(negedge aclk);
            ar_t = s_axi_arvalid && s_axi_arready;
            r_t = s_axi_rvalid;
            rdat = s_axi_rdata;
            rresp_s = s_axi_rresp;
            @(posedge aclk);
            if (ar_t) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
    endtask
    task automatic rchk(input logic [AW-1:0] a, input logic [31:0] m,
            input logic [31:0] e);
        rd(a);
        `CHK(rdat & m, e)
    endtask
    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        aresetn = 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        for (int c = 0; c < 3; c++) begin
            wr(A_CHSEL, 32'(c));
            wr(A_HILIM, 32'h64);
            wr(A_LOLIM, 32'hA);
            wr(A_MODE, t_mode[c]);
        end
        for (int i = 0; i < 7; i++) begin
            adc.send(t_ch[i], t_dat[i], 1'b0);
            rchk(A_ALM, 32'hFFFF, {16'h0, t_alm[i]});
            @(negedge aclk);
            `CHK(alarm_led, |t_alm[i])
        end
        wr(A_CHSEL, 32'h1);
        wr(A_CLR, 32'h3);
        rchk(A_ALM, 32'hFFFF, 32'h100);
        wr(A_CHSEL, 32'h0);
        rchk(A_VAL, 32'hFFFF, 32'h5);
        rchk(A_MAX, 32'hFFFF, 32'hC8);
        rchk(A_MIN, 32'hFFFF, 32'h5);
        wr(A_CLR, 32'h4);
        adc.send(3'h0, 16'h46, 1'b0);
        rchk(A_MAX, 32'hFFFF, 32'h46);
        rchk(A_MIN, 32'hFFFF, 32'h46);
        rchk(A_STAT, 32'h10, 32'h0);
        wr(A_AVGSEL, 32'h3);
        rchk(A_AVG, 32'hFFFF, 32'h25);
        wr(A_AVGSEL, 32'h0);
        rchk(A_AVG, 32'hFFFF, 32'h0);
        wr(A_CHSEL, 32'h3);
        wr(A_RANGE, 32'(RNG_4_20MA));
        rchk(A_RANGE, 32'h77, 32'h4);
        `CHK(adc_range[11:9], RNG_RESET)
        wr(A_CMD, 32'h8);
        rchk(A_RANGE, 32'h77, 32'h44);
        `CHK(adc_range[11:9], RNG_4_20MA)
        wr(A_CTRL, 32'h1);
        adc.send(3'h3, 16'h1234, 1'b1);
        rchk(A_VAL, 32'hFFFF, 32'(VAL_ONES));
        wr(A_CHSEL, 32'h4);
        adc.send(3'h4, 16'h1234, 1'b1);
        rchk(A_VAL, 32'hFFFF, 32'h1234);
        wr(A_CHSEL, 32'h3);
        wr(A_CTRL, 32'h2);
        adc.send(3'h3, 16'h1234, 1'b1);
        rchk(A_VAL, 32'hFFFF, 32'(VAL_ZERO));
        `CHK(adc_integ_sel, 1'b1)
        wr(A_CTRL, 32'h0);
        `CHK(adc_integ_sel, 1'b0)
        wr(A_CMD, 32'h2);
        rchk(A_STAT, 32'h2, 32'h0);
        wr(A_CTRL, 32'h4);
        wr(A_CMD, 32'h2);
        rchk(A_STAT, 32'h2, 32'h2);
        `CHK(adc_cal_run, 1'b1)
        repeat (50) @(posedge aclk);
        rchk(A_STAT, 32'h6, 32'h4);
        `CHK(adc_cal_run, 1'b0)
        wr(A_CMD, 32'h4);
        `CHK(commit_n, 1)
        rchk(A_STAT, 32'h8, 32'h8);
        wr(A_CMD, 32'h1);
        rchk(A_STAT, 32'h1, 32'h1);
        repeat (30) @(posedge aclk);
        @(negedge aclk);
        `CHK(status_led, 1'b0)
        rd(8'h3C);
        `CHK(rresp_s, RESP_SLVERR)
        `CHK(rdat, 32'h0)
        `CHK(bresp_s, RESP_OK)
        complete_run();
    end
endmodule
bind aim_top aim_assertions #(
    .LOCATE_CYCLES(LOCATE_CYCLES),
    .CAL_CYCLES(CAL_CYCLES)
) chk (.*);
